// *** cdt_pkg.sv ***
/*
 * Constants, command codes and helpers of the data transfer unit.
 * Assumes one 25 MHz clock and a memory with a same-clock acknowledge.
 */
package cdt_pkg;

    // Data and register file geometry.
    localparam int DATA_W   = 32;
    localparam int NUM_REGS = 8;
    localparam logic [2:0] SP_INDEX = 3'h7;
    localparam logic [31:0] GPR_RESET = 32'h0000_0000;

    // Operand size codes; the fourth code is refused.
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [1:0] SIZE_BAD  = 2'h3;

    // Stack pointer steps per operand size, in bytes.
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;

    // Command codes.
    localparam logic [3:0] OP_MOVE_RR    = 4'h0;
    localparam logic [3:0] OP_MOVE_IMM   = 4'h1;
    localparam logic [3:0] OP_MOVE_LOAD  = 4'h2;
    localparam logic [3:0] OP_MOVE_STORE = 4'h3;
    localparam logic [3:0] OP_POP        = 4'h4;
    localparam logic [3:0] OP_PUSH       = 4'h5;
    localparam logic [3:0] OP_MLD        = 4'h6;
    localparam logic [3:0] OP_MST        = 4'h7;
    localparam logic [3:0] OP_PERIPH_IN  = 4'h8;
    localparam logic [3:0] OP_PERIPH_OUT = 4'h9;

    // Memory addressing modes for general moves.
    localparam logic [1:0] AM_ABS     = 2'h0;
    localparam logic [1:0] AM_IND     = 2'h1;
    localparam logic [1:0] AM_POSTINC = 2'h2;
    localparam logic [1:0] AM_PREDEC  = 2'h3;

    // Address or immediate field length codes.
    localparam logic [1:0] LEN_8  = 2'h0;
    localparam logic [1:0] LEN_16 = 2'h1;
    localparam logic [1:0] LEN_24 = 2'h2;
    localparam logic [1:0] LEN_32 = 2'h3;

    // Register list limits.
    localparam logic [2:0] LIST_MIN = 3'h2;
    localparam logic [3:0] LIST_END = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_MEM  = 2'b10
    } cdt_state_type;

    // Bytes moved by one access of the given size.
    function automatic logic [31:0] size_step(input logic [1:0] size);
        return (size == SIZE_BYTE) ? STEP_BYTE : (size == SIZE_WORD) ? STEP_WORD : STEP_LONG;
    endfunction

    // Widens a field; short forms sign extend, the 24-bit form zero extends.
    function automatic logic [31:0] ext_field(input logic [31:0] v, input logic [1:0] len);
        case (len)
            LEN_8:   return {{24{v[7]}}, v[7:0]};
            LEN_16:  return {{16{v[15]}}, v[15:0]};
            LEN_24:  return {8'h00, v[23:0]};
            default: return v;
        endcase
    endfunction

endpackage

// *** cdt_rf_if.sv ***
/*
 * Bundle between the transfer sequencer and its general register file.
 * Assumes both ends share sys_clk; all read ports are combinational.
 */
`timescale 1ns/10ps
interface cdt_rf_if;
    logic [3:0]  rd_code;
    logic [1:0]  rd_size;
    logic [31:0] rd_data;
    logic [2:0]  ptr_idx;
    logic [31:0] ptr_data;
    logic        wr_en;
    logic [3:0]  wr_code;
    logic [1:0]  wr_size;
    logic [31:0] wr_data;
    logic        pw_en;
    logic [2:0]  pw_idx;
    logic [31:0] pw_data;
    logic [2:0]  pk_idx;
    logic [31:0] pk_data;
    logic [31:0] sp_data;

    modport rf (
        input  rd_code, rd_size, ptr_idx, wr_en, wr_code, wr_size, wr_data,
        input  pw_en, pw_idx, pw_data, pk_idx,
        output rd_data, ptr_data, pk_data, sp_data
    );
    modport core (
        output rd_code, rd_size, ptr_idx, wr_en, wr_code, wr_size, wr_data,
        output pw_en, pw_idx, pw_data, pk_idx,
        input  rd_data, ptr_data, pk_data, sp_data
    );
endinterface

// *** cdt_regfile.sv ***
/*
 * Eight 32-bit general registers with sized access to halves and bytes.
 * Assumes a data write may win over a pointer update at one register.
 */
`timescale 1ns/10ps
module cdt_regfile (
    input wire logic sys_clk,
    input wire logic rst_n,
    cdt_rf_if.rf     rf
);
    logic [31:0] gpr_reg [cdt_pkg::NUM_REGS];

    // Code bit 3 picks the upper half for words and the low byte for bytes.
    function automatic logic [31:0] read_sized(input logic [31:0] r, input logic hi,
                                               input logic [1:0] size);
        logic [31:0] v;
        v = r;
        if (size == cdt_pkg::SIZE_WORD) begin
            v = hi ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
        end else if (size == cdt_pkg::SIZE_BYTE) begin
            v = hi ? {24'h000000, r[7:0]} : {24'h000000, r[15:8]};
        end
        return v;
    endfunction

    // Merges a sized write into the old value, leaving the other parts alone.
    function automatic logic [31:0] merge(input logic [31:0] r, input logic hi,
                                          input logic [1:0] size, input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (size == cdt_pkg::SIZE_WORD) begin
            v = hi ? {d[15:0], r[15:0]} : {r[31:16], d[15:0]};
        end else if (size == cdt_pkg::SIZE_BYTE) begin
            v = hi ? {r[31:8], d[7:0]} : {r[31:16], d[7:0], r[7:0]};
        end
        return v;
    endfunction

    // Read ports.
    assign rf.rd_data  = read_sized(gpr_reg[rf.rd_code[2:0]], rf.rd_code[3], rf.rd_size);
    assign rf.ptr_data = gpr_reg[rf.ptr_idx];
    assign rf.pk_data  = gpr_reg[rf.pk_idx];
    assign rf.sp_data  = gpr_reg[cdt_pkg::SP_INDEX];

    // Data write wins over a pointer update so a pop into the pointer keeps the loaded value.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        for (int i = 0; i < cdt_pkg::NUM_REGS; i++) begin
            if (!rst_n) begin
                gpr_reg[i] <= cdt_pkg::GPR_RESET;
            end else if (rf.wr_en && rf.wr_code[2:0] == 3'(i)) begin
                gpr_reg[i] <= merge(gpr_reg[i], rf.wr_code[3], rf.wr_size, rf.wr_data);
            end else if (rf.pw_en && rf.pw_idx == 3'(i)) begin
                gpr_reg[i] <= rf.pw_data;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // A byte write to the low byte of the pointer register leaves bits 31:8 alone.
    property p_byte_keep;
        rf.wr_en && rf.wr_size == cdt_pkg::SIZE_BYTE && rf.wr_code == 4'hf && !rf.pw_en
        |=> rf.sp_data[31:8] == $past(rf.sp_data[31:8]);
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("byte write disturbed other bits");
endmodule

// *** cdt_transfer_unit.sv ***
/*
 * Execution unit for the data transfer group: general moves, single register
 * pop and push, and multi-register stack load and store.
 * Assumes the command source and the memory run on sys_clk, that memory holds
 * mem_ack low unless mem_req is high, and that one command runs at a time.
 */
`timescale 1ns/10ps
module cdt_transfer_unit (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [3:0]  cmd_op,
    input  wire logic [1:0]  cmd_size,
    input  wire logic [3:0]  cmd_dst,
    input  wire logic [3:0]  cmd_src,
    input  wire logic [2:0]  cmd_ea,
    input  wire logic [1:0]  cmd_mode,
    input  wire logic [1:0]  cmd_len,
    input  wire logic [31:0] cmd_value,
    input  wire logic [2:0]  cmd_count,
    output logic             mem_req,
    output logic             mem_we,
    output logic [1:0]       mem_size,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             done,
    output logic             err,
    input  wire logic [2:0]  peek_idx,
    output logic [31:0]      peek_data
);
    cdt_rf_if rf ();

    cdt_regfile u_regfile (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .rf      (rf.rf)
    );

    cdt_pkg::cdt_state_type state_reg, state_next;
    logic [3:0]  op_reg;
    logic [1:0]  size_reg;
    logic [3:0]  dst_reg;
    logic [3:0]  src_reg;
    logic [2:0]  ea_reg;
    logic [1:0]  mode_reg;
    logic [31:0] value_reg;
    logic [2:0]  cnt_reg;
    logic [2:0]  cur_reg;
    logic        done_reg;
    logic        err_reg;
    logic        mem_req_reg;
    logic        mem_we_reg;
    logic [1:0]  mem_size_reg;
    logic [31:0] mem_addr_reg;
    logic [31:0] mem_wdata_reg;
    logic [31:0] peek_reg;

    // Command legality check, done at acceptance so nothing illegal starts.
    wire       accept    = cmd_valid && cmd_ready;
    wire       c_stack1  = cmd_op == cdt_pkg::OP_POP || cmd_op == cdt_pkg::OP_PUSH;
    wire       c_multi   = cmd_op == cdt_pkg::OP_MLD || cmd_op == cdt_pkg::OP_MST;
    wire [3:0] list_sum  = {1'b0, cmd_src[2:0]} + {1'b0, cmd_count};
    wire       list_ok   = cmd_count >= cdt_pkg::LIST_MIN && list_sum <= cdt_pkg::LIST_END;
    wire       c_periph  = cmd_op == cdt_pkg::OP_PERIPH_IN || cmd_op == cdt_pkg::OP_PERIPH_OUT;
    wire       cmd_legal = cmd_size != cdt_pkg::SIZE_BAD && !c_periph
                           && cmd_op <= cdt_pkg::OP_MST
                           && (!c_stack1 || cmd_size != cdt_pkg::SIZE_BYTE)
                           && (!c_multi || (cmd_size == cdt_pkg::SIZE_LONG && list_ok));
    wire [2:0] list_top  = list_sum[2:0] - 3'h1;

    // Operation class decode of the running command.
    wire is_rr    = op_reg == cdt_pkg::OP_MOVE_RR;
    wire is_imm   = op_reg == cdt_pkg::OP_MOVE_IMM;
    wire is_mld   = op_reg == cdt_pkg::OP_MLD;
    wire is_mst   = op_reg == cdt_pkg::OP_MST;
    wire is_multi = is_mld || is_mst;
    wire is_stack = op_reg == cdt_pkg::OP_POP || op_reg == cdt_pkg::OP_PUSH || is_multi;
    wire is_write = op_reg == cdt_pkg::OP_MOVE_STORE || op_reg == cdt_pkg::OP_PUSH || is_mst;
    wire reg_only = is_rr || is_imm;
    wire gen_mem  = op_reg == cdt_pkg::OP_MOVE_LOAD || op_reg == cdt_pkg::OP_MOVE_STORE;

    // Address generation; stack forms always use the pointer register.
    wire        is_pre    = (gen_mem && mode_reg == cdt_pkg::AM_PREDEC)
                            || op_reg == cdt_pkg::OP_PUSH || is_mst;
    wire        is_post   = (gen_mem && mode_reg == cdt_pkg::AM_POSTINC)
                            || op_reg == cdt_pkg::OP_POP || is_mld;
    wire [2:0]  base_idx  = is_stack ? cdt_pkg::SP_INDEX : ea_reg;
    wire [31:0] step      = cdt_pkg::size_step(size_reg);
    wire [31:0] base      = rf.ptr_data;
    wire [31:0] exec_addr = (gen_mem && mode_reg == cdt_pkg::AM_ABS) ? value_reg
                            : (is_pre ? base - step : base);
    wire        last_beat = !is_multi || cnt_reg == 3'h1;
    wire        mem_done  = state_reg == cdt_pkg::ST_MEM && mem_ack;
    wire [3:0]  list_code = {1'b0, cur_reg};

    // Register file hookup; sized data and pointer updates use separate ports.
    assign rf.ptr_idx = base_idx;
    assign rf.rd_code = is_mst ? list_code : src_reg;
    assign rf.rd_size = size_reg;
    assign rf.wr_en   = (state_reg == cdt_pkg::ST_EXEC && reg_only) || (mem_done && !is_write);
    assign rf.wr_code = is_mld ? list_code : dst_reg;
    assign rf.wr_size = size_reg;
    assign rf.wr_data = is_rr ? rf.rd_data : (is_imm ? value_reg : mem_rdata);
    assign rf.pw_en   = mem_done && (is_pre || is_post);
    assign rf.pw_idx  = base_idx;
    assign rf.pw_data = is_pre ? base - step : base + step;
    assign rf.pk_idx  = peek_idx;

    // Sequencer: one register-only cycle, or one memory beat per list entry.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            cdt_pkg::ST_IDLE: state_next = (accept && cmd_legal) ? cdt_pkg::ST_EXEC
                                                                 : cdt_pkg::ST_IDLE;
            cdt_pkg::ST_EXEC: state_next = reg_only ? cdt_pkg::ST_IDLE : cdt_pkg::ST_MEM;
            cdt_pkg::ST_MEM: begin
                if (mem_ack) begin
                    state_next = last_beat ? cdt_pkg::ST_IDLE : cdt_pkg::ST_EXEC;
                end
            end
        endcase
    end

    // State and completion strobes.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= cdt_pkg::ST_IDLE;
            done_reg  <= 1'b0;
            err_reg   <= 1'b0;
            peek_reg  <= cdt_pkg::GPR_RESET;
        end else begin
            state_reg <= state_next;
            done_reg  <= (state_reg == cdt_pkg::ST_EXEC && reg_only) || (mem_done && last_beat);
            err_reg   <= accept && !cmd_legal;
            peek_reg  <= rf.pk_data;
        end
    end

    // Command capture; the list pointer walks down for loads and up for stores.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_reg    <= cdt_pkg::OP_MOVE_RR;
            size_reg  <= cdt_pkg::SIZE_BYTE;
            dst_reg   <= 4'h0;
            src_reg   <= 4'h0;
            ea_reg    <= 3'h0;
            mode_reg  <= cdt_pkg::AM_ABS;
            value_reg <= 32'h0000_0000;
            cnt_reg   <= 3'h0;
            cur_reg   <= 3'h0;
        end else if (accept) begin
            op_reg    <= cmd_op;
            size_reg  <= cmd_size;
            dst_reg   <= cmd_dst;
            src_reg   <= cmd_src;
            ea_reg    <= cmd_ea;
            mode_reg  <= cmd_mode;
            value_reg <= cdt_pkg::ext_field(cmd_value, cmd_len);
            cnt_reg   <= cmd_count;
            cur_reg   <= (cmd_op == cdt_pkg::OP_MLD) ? list_top : cmd_src[2:0];
        end else if (mem_done) begin
            cnt_reg   <= cnt_reg - 3'h1;
            cur_reg   <= is_mld ? cur_reg - 3'h1 : cur_reg + 3'h1;
        end
    end

    // Memory request stays up from issue until the acknowledge cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_reg   <= 1'b0;
            mem_we_reg    <= 1'b0;
            mem_size_reg  <= cdt_pkg::SIZE_BYTE;
            mem_addr_reg  <= 32'h0000_0000;
            mem_wdata_reg <= 32'h0000_0000;
        end else if (state_reg == cdt_pkg::ST_EXEC && !reg_only) begin
            mem_req_reg   <= 1'b1;
            mem_we_reg    <= is_write;
            mem_size_reg  <= size_reg;
            mem_addr_reg  <= exec_addr;
            mem_wdata_reg <= rf.rd_data;
        end else if (mem_done) begin
            mem_req_reg   <= 1'b0;
        end
    end

    assign cmd_ready = state_reg == cdt_pkg::ST_IDLE;
    assign mem_req   = mem_req_reg;
    assign mem_we    = mem_we_reg;
    assign mem_size  = mem_size_reg;
    assign mem_addr  = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign done      = done_reg;
    assign err       = err_reg;
    assign peek_data = peek_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Register moves finish two edges after acceptance with a single-cycle done.
    property p_move_done;
        accept && cmd_legal && cmd_op == cdt_pkg::OP_MOVE_RR |-> ##2 done ##1 !done;
    endproperty
    a_move_done: assert property (p_move_done) else $error("move done timing wrong");

    property p_pop_read;
        accept && cmd_legal && cmd_op == cdt_pkg::OP_POP
        |-> ##2 mem_req && !mem_we && mem_addr == rf.sp_data;
    endproperty
    a_pop_read: assert property (p_pop_read) else $error("pop read address wrong");

    property p_push_word;
        $rose(mem_req) && op_reg == cdt_pkg::OP_PUSH && size_reg == cdt_pkg::SIZE_WORD
        |-> mem_we && mem_addr == rf.sp_data - 32'h2;
    endproperty
    a_push_word: assert property (p_push_word) else $error("push word address wrong");

    property p_mld_step;
        mem_req && mem_ack && is_mld && cur_reg != cdt_pkg::SP_INDEX
        |=> rf.sp_data == $past(rf.sp_data) + 32'h4;
    endproperty
    a_mld_step: assert property (p_mld_step) else $error("multi load step wrong");

    property p_mst_step;
        mem_req && mem_ack && is_mst |-> mem_we ##1 rf.sp_data == $past(rf.sp_data) - 32'h4;
    endproperty
    a_mst_step: assert property (p_mst_step) else $error("multi store step wrong");

    property p_periph_err;
        accept && c_periph |=> err && cmd_ready && !mem_req;
    endproperty
    a_periph_err: assert property (p_periph_err) else $error("peripheral move not refused");

    property p_imm_len8;
        accept && cmd_len == cdt_pkg::LEN_8
        |=> value_reg == {{24{$past(cmd_value[7])}}, $past(cmd_value[7:0])};
    endproperty
    a_imm_len8: assert property (p_imm_len8) else $error("short field widened wrongly");

    property p_pop_long_step;
        mem_req && mem_ack && op_reg == cdt_pkg::OP_POP && size_reg == cdt_pkg::SIZE_LONG
        && dst_reg[2:0] != cdt_pkg::SP_INDEX |=> rf.sp_data == $past(rf.sp_data) + 32'h4;
    endproperty
    a_pop_long_step: assert property (p_pop_long_step) else $error("pop step wrong");

    c_pop: cover property (mem_ack && op_reg == cdt_pkg::OP_POP);
    c_mst_done: cover property (done && is_mst);
    c_err: cover property (err);
endmodule

// *** cdt_mem_model.sv ***
/*
 * Behavioural byte-addressed memory of 256 bytes, big-endian, for the transfer unit.
 * Assumes the unit holds each request until the edge after mem_ack.
 */
`timescale 1ns/10ps
module cdt_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [1:0]  mem_size,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [2:0]  lat,
    output logic [31:0]      mem_rdata,
    output logic             mem_ack
);
    logic [7:0]  mem [0:255];
    logic [2:0]  wait_reg;
    logic [31:0] noise_reg;
    logic [31:0] rd_val;
    int          nb;

    // The answer comes after lat waiting cycles; zero answers in the first cycle.
    assign mem_ack = mem_req && (wait_reg >= lat);
    assign nb = 1 << mem_size;
    assign mem_rdata = mem_ack ? rd_val : noise_reg;

    // Unused lanes carry a toggling pattern, so stale or unsized data never looks right.
    always_comb begin
        rd_val = noise_reg;
        for (int i = 0; i < nb; i++) begin
            rd_val[8*(nb-1-i) +: 8] = mem[mem_addr[7:0] + 8'(i)];
        end
    end

    // Counts the wait and stores written bytes at the acknowledged edge.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg  <= 3'h0;
            noise_reg <= 32'h5a3c_96e1;
        end else begin
            noise_reg <= ~noise_reg;
            wait_reg  <= (mem_req && !mem_ack) ? wait_reg + 3'h1 : 3'h0;
            if (mem_req && mem_ack && mem_we) begin
                for (int i = 0; i < nb; i++) begin
                    mem[mem_addr[7:0] + 8'(i)] <= mem_wdata[8*(nb-1-i) +: 8];
                end
            end
        end
    end
endmodule

// *** cpu_data_transfer_ops_tb.sv ***
/*
 * Self-checking bench of the transfer unit against a behavioural memory.
 * Assumes the package, register file and memory model are compiled first.
 */
`timescale 1ns/10ps
module cpu_data_transfer_ops_tb;
    logic        sys_clk, rst_n, cmd_valid, cmd_ready, done, err, mem_req, mem_we, mem_ack;
    logic [3:0]  cmd_op, cmd_dst, cmd_src;
    logic [1:0]  cmd_size, cmd_mode, cmd_len, mem_size, sz;
    logic [2:0]  cmd_ea, cmd_count, peek_idx, lat;
    logic [31:0] cmd_value, mem_addr, mem_wdata, mem_rdata, peek_data, seed, x, y;
    logic [31:0] gpr [0:7], sv [0:7];
    logic [31:0] aq [$];
    logic        rdy;
    int          n_fail, checks_done, cycles, n_acc, k, n0, f, n;
    // Refused: byte stack ops, peripheral moves, bad size, bad lists, bad op.
    logic [3:0]  rop [9] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'h0, 4'h6, 4'h6, 4'h7, 4'hb};
    logic [1:0]  rsz [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [3:0]  rsr [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h6, 4'h0};
    int          rcn [9] = '{0, 0, 0, 0, 0, 3, 1, 3, 2};

    cdt_transfer_unit dut_u (.sys_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_size,
        .cmd_dst, .cmd_src, .cmd_ea, .cmd_mode, .cmd_len, .cmd_value, .cmd_count, .mem_req,
        .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .done, .err,
        .peek_idx, .peek_data);
    cdt_mem_model mem_u (.sys_clk, .rst_n, .mem_req, .mem_we, .mem_size, .mem_addr,
        .mem_wdata, .lat, .mem_rdata, .mem_ack);

    // Free-running 25 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Logs acknowledged addresses and cuts a hung run short.
    always @(posedge sys_clk) begin
        cycles++;
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            aq.push_back(mem_addr);
            n_acc++;
        end
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] step(input logic [1:0] s);
        return 32'h1 << s;
    endfunction

    // Short fields sign extend, the 24-bit field zero extends.
    function automatic logic [31:0] fext(input logic [31:0] v, input logic [1:0] l);
        case (l)
            2'h0: return {{24{v[7]}}, v[7:0]};
            2'h1: return {{16{v[15]}}, v[15:0]};
            2'h2: return {8'h00, v[23:0]};
            default: return v;
        endcase
    endfunction

    // Sized view of a register code: bit 3 picks the half or the byte.
    function automatic logic [31:0] rd(input logic [3:0] c, input logic [1:0] s);
        logic [31:0] r;
        r = gpr[c[2:0]];
        if (s == 2'h1) return c[3] ? {16'h0, r[31:16]} : {16'h0, r[15:0]};
        if (s == 2'h0) return c[3] ? {24'h0, r[7:0]} : {24'h0, r[15:8]};
        return r;
    endfunction

    task automatic wr(input logic [3:0] c, input logic [1:0] s, input logic [31:0] d);
        if (s == 2'h2) gpr[c[2:0]] = d;
        else if (s == 2'h0 && c[3]) gpr[c[2:0]][7:0] = d[7:0];
        else if (s == 2'h0) gpr[c[2:0]][15:8] = d[7:0];
        else if (c[3]) gpr[c[2:0]][31:16] = d[15:0];
        else gpr[c[2:0]][15:0] = d[15:0];
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    task automatic peek_chk(input logic [2:0] i);
        peek_idx = i;
        @(posedge sys_clk);
        #1;
        chk("register", gpr[i], peek_data);
    endtask

    task automatic chk_all();
        for (int i = 0; i < 8; i++) peek_chk(3'(i));
    endtask

    // Offers one command while idle and waits a bounded time for done or err.
    task automatic run(input logic [3:0] op, input logic [1:0] s, input logic [3:0] d, r,
                       input logic [1:0] md, ln, input logic [31:0] val, input int c,
                       input logic e);
        logic [31:0] t;
        t = rnd();
        {cmd_op, cmd_size, cmd_dst, cmd_src, cmd_mode, cmd_len} = {op, s, d, r, md, ln};
        {cmd_value, cmd_count, lat, cmd_valid} = {val, 3'(c), 1'b0, t[1:0], 1'b1};
        n0 = n_acc;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        rdy = cmd_ready;
        k = 0;
        while (done !== 1'b1 && err !== 1'b1 && k < 200) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        chk("completed", e, done);
        chk("ready", !e, rdy);
        if (!e) begin
            chk("err latency", 0, k);
            chk("accesses on refusal", n0, n_acc);
            @(posedge sys_clk);
            #1;
        end else if (op < 4'h2) chk("move latency", 1, k);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        {rst_n, cmd_valid, cmd_op, cmd_size, cmd_dst, cmd_src, cmd_mode, cmd_len} = '0;
        {cmd_value, cmd_count, peek_idx, lat, cmd_ea} = {32'h0, 9'h0, 3'h1};
        seed = 32'h0000_2e27;
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk("ready after reset", 1, cmd_ready);
        foreach (gpr[i]) gpr[i] = cdt_pkg::GPR_RESET;
        chk_all();
        // Immediate loads over every field length and size.
        for (int j = 0; j < 12; j++) begin
            x = rnd();
            y = rnd();
            wr(y[3:0], 2'(j % 3), fext(x, 2'(j / 3)));
            run(cdt_pkg::OP_MOVE_IMM, 2'(j % 3), y[3:0], 4'h0, 2'h0, 2'(j / 3), x, 0, 1);
            peek_chk(y[2:0]);
        end
        repeat (24) begin
            x = rnd();
            sz = x[9:8] % 2'h3;
            wr(x[3:0], sz, rd(x[7:4], sz));
            run(cdt_pkg::OP_MOVE_RR, sz, x[3:0], x[7:4], 2'h0, 2'h0, 32'h0, 0, 1);
            peek_chk(x[2:0]);
        end
        $display("test register moves done");
        // The pointer is only ever moved by words or longs here.
        run(cdt_pkg::OP_MOVE_IMM, 2'h2, 4'h7, 4'h0, 2'h0, 2'h2, 32'hff00_0080, 0, 1);
        gpr[7] = 32'h80;
        repeat (8) begin
            x = rnd() & 32'h1bb;
            sz = x[8] ? cdt_pkg::SIZE_LONG : cdt_pkg::SIZE_WORD;
            y = rd(x[3:0], sz);
            aq.delete();
            run(cdt_pkg::OP_PUSH, sz, 4'h0, x[3:0], 2'h0, 2'h0, 32'h0, 0, 1);
            gpr[7] -= step(sz);
            wr(x[7:4], sz, y);
            run(cdt_pkg::OP_POP, sz, x[7:4], 4'h0, 2'h0, 2'h0, 32'h0, 0, 1);
            chk("push address", gpr[7], aq[0]);
            chk("pop address", gpr[7], aq[1]);
            gpr[7] += step(sz);
            peek_chk(x[6:4]);
            peek_chk(3'h7);
        end
        // Lists saved, overwritten, then restored, stopping short of the pointer.
        repeat (4) begin
            x = rnd();
            f = x[7:0] % 5;
            n = 2 + x[15:8] % (6 - f);
            aq.delete();
            sv = gpr;
            run(cdt_pkg::OP_MST, 2'h2, 4'h0, 4'(f), 2'h0, 2'h0, 32'h0, n, 1);
            for (int i = 0; i < n; i++) chk("save address", gpr[7] - 4 * (i + 1), aq[i]);
            for (int i = f; i < f + n; i++) begin
                gpr[i] = rnd();
                run(cdt_pkg::OP_MOVE_IMM, 2'h2, 4'(i), 4'h0, 2'h0, 2'h3, gpr[i], 0, 1);
            end
            aq.delete();
            run(cdt_pkg::OP_MLD, 2'h2, 4'h0, 4'(f), 2'h0, 2'h0, 32'h0, n, 1);
            for (int i = 0; i < n; i++) chk("restore address", gpr[7] - 4 * (n - i), aq[i]);
            gpr = sv;
            chk_all();
        end
        $display("test stack transfers done");
        run(cdt_pkg::OP_MOVE_IMM, 2'h2, 4'h1, 4'h0, 2'h0, 2'h0, 32'h40, 0, 1);
        gpr[1] = 32'h40;
        for (int s = 0; s < 3; s++) begin
            y = rd(4'hd, 2'(s));
            aq.delete();
            run(cdt_pkg::OP_MOVE_STORE, 2'(s), 4'h0, 4'hd, cdt_pkg::AM_PREDEC, 2'h0, 32'h0, 0, 1);
            gpr[1] -= step(2'(s));
            wr(4'h6, 2'(s), y);
            run(cdt_pkg::OP_MOVE_LOAD, 2'(s), 4'h6, 4'h0, cdt_pkg::AM_POSTINC, 2'h0, 32'h0, 0, 1);
            chk("store address", gpr[1], aq[0]);
            chk("load address", gpr[1], aq[1]);
            gpr[1] += step(2'(s));
            chk_all();
        end
        aq.delete();
        run(cdt_pkg::OP_MOVE_STORE, 2'h2, 4'h0, 4'h3, cdt_pkg::AM_IND, 2'h0, 32'h0, 0, 1);
        gpr[2] = gpr[3];
        run(cdt_pkg::OP_MOVE_LOAD, 2'h2, 4'h2, 4'h0, cdt_pkg::AM_ABS, 2'h0, 32'habcd_ef40, 0, 1);
        chk("indirect address", 32'h40, aq[0]);
        chk("absolute address", 32'h40, aq[1]);
        chk_all();
        $display("test memory moves done");
        foreach (rop[i]) begin
            run(rop[i], rsz[i], 4'h0, rsr[i], 2'h0, 2'h0, 32'h0, rcn[i], 0);
            chk_all();
        end
        $display("test refusals done");
        finish_test();
    end
endmodule
